// [ssp_slave.sv]
// Purpose: select-gated two-wire management slave port with register access
// Assumes: pins arrive asynchronously; open-drain pins as in/out/enable
// Notes:   never stretches the clock; every data byte of a write message goes to the same register
// Function
// - port works only while select is high
// - select low: ignore bus, drive nothing
// - port stays active in standby
// - recognise fixed slave address 1010110
// - data stable while serial clock high
// - start: data falls while clock high
// - stop: data rises while clock high
// - idle after bus-free or clock-high limit
// - support register writes and register reads
// - acknowledge address, register and data bytes
// - clock-low timeout abandons the transfer
// - total clock stretching under 2 ms
// - ready well within 500 ms of reset
// - read: repeated start, acknowledge, send byte
`timescale 1ns/1ps
module ssp_slave import ssp_pkg::*; #(
  parameter int unsigned TO_CYC    = TIMEOUT_CYC,
  parameter int unsigned READY_DLY = READY_CYC
) (
  input  wire logic       clk,
  input  wire logic       clk_en,
  input  wire logic       sys_rst,
  input  wire logic       port_sel,
  input  wire logic       serial_mgmt_clock_i,
  output logic            serial_mgmt_clock_o,
  output logic            serial_mgmt_clock_oe,
  input  wire logic       mgmt_data_i,
  output logic            mgmt_data_o,
  output logic            mgmt_data_oe,
  output logic            port_ready,
  output logic            bus_idle,
  output logic            timeout_evt,
  output logic            wr_stb,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data
);

  localparam int unsigned TO_W = $clog2(TO_CYC + 1);

  typedef struct packed {
    ssp_state_e       st;
    logic             sel_m, sel_s;
    logic             scl_m, scl_s, scl_p;
    logic             sda_m, sda_s, sda_p;
    logic [7:0]       shift;
    logic [3:0]       cnt;
    logic [1:0]       idx;
    logic             rw;
    logic [7:0]       reg_addr;
    logic [HI_W-1:0]  hi_cnt;
    logic             stop_seen;
    logic [TO_W-1:0]  low_cnt;
    logic [RDY_W-1:0] rdy_cnt;
    logic             ready;
    logic             sda_o, sda_oe, scl_o, scl_oe;
    logic             idle, timeout;
    logic             wr_stb;
    logic [7:0]       wr_addr, wr_data;
  } ssp_state_s;

  ssp_state_s q;
  ssp_state_s d;
  logic [7:0] rdata;
  logic       scl_rise, scl_fall, start_c, stop_c, to_hit;

  ////////////////////////////////////////////////////////////////////////////
  // bus conditions, seen only on the second synchroniser stage onward
  assign scl_rise = q.scl_s && !q.scl_p;
  assign scl_fall = !q.scl_s && q.scl_p;
  assign start_c  = q.scl_s && q.scl_p && q.sda_p && !q.sda_s;
  assign stop_c   = q.scl_s && q.scl_p && !q.sda_p && q.sda_s;
  assign to_hit   = !q.scl_s && (q.low_cnt == TO_W'(TO_CYC - 1));

  // next-state logic for the whole port
  always_comb begin
    d         = q;
    d.wr_stb  = 1'b0;
    d.timeout = 1'b0;
    d.sel_m   = port_sel;
    d.sel_s   = q.sel_m;
    d.scl_m   = serial_mgmt_clock_i;
    d.scl_s   = q.scl_m;
    d.scl_p   = q.scl_s;
    d.sda_m   = mgmt_data_i;
    d.sda_s   = q.sda_m;
    d.sda_p   = q.sda_s;
    // readiness delay after reset, far below the power-up bound
    if (!q.ready) begin
      d.rdy_cnt = q.rdy_cnt + 1'b1;
      d.ready   = (q.rdy_cnt == RDY_W'(READY_DLY - 1));
    end
    // both lines high: count toward bus-free and clock-high limits
    if (q.scl_s && q.sda_s) begin
      if (q.hi_cnt != HI_W'(HIGH_CYC)) d.hi_cnt = q.hi_cnt + 1'b1;
    end else begin
      d.hi_cnt = '0;
    end
    d.idle = (q.stop_seen && q.hi_cnt >= HI_W'(BUF_CYC))
          || (q.hi_cnt == HI_W'(HIGH_CYC));
    if (stop_c) d.stop_seen = 1'b1;
    if (start_c) d.stop_seen = 1'b0;
    // clock-low timer saturates so the timeout fires once per low phase
    if (q.scl_s) begin
      d.low_cnt = '0;
    end else if (q.low_cnt != TO_W'(TO_CYC)) begin
      d.low_cnt = q.low_cnt + 1'b1;
    end
    // no clock stretching at all keeps the stretch budget at zero
    d.scl_oe = 1'b0;
    // select and readiness gate the port; standby has no say here
    if (!q.sel_s || !q.ready) begin
      d.st     = ST_IDLE;
      d.sda_oe = 1'b0;
    end else if (to_hit) begin
      d.st      = ST_IDLE;
      d.sda_oe  = 1'b0;
      d.timeout = 1'b1;
    end else if (start_c) begin
      d.st     = ST_RX;
      d.cnt    = '0;
      d.idx    = '0;
      d.sda_oe = 1'b0;
    end else if (stop_c) begin
      d.st     = ST_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        ST_IDLE: begin
          d.sda_oe = 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            d.shift = {q.shift[6:0], q.sda_s};
            d.cnt   = q.cnt + 1'b1;
          end else if (scl_fall && q.cnt == BYTE_BITS) begin
            // data line only moves while the clock is low
            d.st     = ST_ACK;
            d.sda_oe = 1'b1;
            if (q.idx == 2'h0) begin
              d.rw = q.shift[0];
              if (q.shift[7:1] != SLAVE_ADDR) begin
                d.st     = ST_IDLE;
                d.sda_oe = 1'b0;
              end
            end else if (q.idx == 2'h1) begin
              d.reg_addr = q.shift;
            end else if (q.reg_addr >= RO_COUNT && q.reg_addr < REG_LIMIT) begin
              d.wr_stb  = 1'b1;
              d.wr_addr = q.reg_addr;
              d.wr_data = q.shift;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            d.cnt = '0;
            if (q.idx == 2'h0 && q.rw) begin
              d.st     = ST_TX;
              d.shift  = rdata;
              d.sda_oe = !rdata[7];
            end else begin
              d.st     = ST_RX;
              d.sda_oe = 1'b0;
              if (q.idx != IDX_DATA) d.idx = q.idx + 1'b1;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            d.cnt    = q.cnt + 1'b1;
            d.shift  = {q.shift[6:0], 1'b0};
            d.sda_oe = !q.shift[6];
            if (q.cnt == BYTE_BITS - 4'h1) begin
              d.st     = ST_RACK;
              d.cnt    = '0;
              d.sda_oe = 1'b0;
            end
          end
        end
        ST_RACK: begin
          // host ack asks for the next location, nack ends the read
          if (scl_rise) begin
            d.cnt = q.sda_s ? 4'h0 : BYTE_BITS;
            if (!q.sda_s) d.reg_addr = q.reg_addr + 8'h01;
          end else if (scl_fall) begin
            if (q.cnt == BYTE_BITS) begin
              d.st     = ST_TX;
              d.cnt    = '0;
              d.shift  = rdata;
              d.sda_oe = !rdata[7];
            end else begin
              d.st = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // single state register, frozen while the clock enable is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q       <= '0;
      q.st    <= ST_IDLE;
      // synchronisers start at the pulled-up idle level: no false edge after reset
      {q.scl_m, q.scl_s, q.scl_p} <= 3'h7;
      {q.sda_m, q.sda_s, q.sda_p} <= 3'h7;
    end else if (clk_en) begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration store; narrow address, range checked before writing
  ssp_regmem u_mem (
    .clk     (clk),
    .clk_en  (clk_en),
    .sys_rst (sys_rst),
    .we      (q.wr_stb),
    .waddr   (q.wr_addr[REG_AW-1:0]),
    .wdata   (q.wr_data),
    .raddr   (q.reg_addr[REG_AW-1:0]),
    .rdata_q (rdata)
  );

  assign serial_mgmt_clock_o  = q.scl_o;
  assign serial_mgmt_clock_oe = q.scl_oe;
  assign mgmt_data_o          = q.sda_o;
  assign mgmt_data_oe         = q.sda_oe;
  assign port_ready           = q.ready;
  assign bus_idle             = q.idle;
  assign timeout_evt          = q.timeout;
  assign wr_stb               = q.wr_stb;
  assign wr_addr              = q.wr_addr;
  assign wr_data              = q.wr_data;

  ////////////////////////////////////////////////////////////////////////////
  // checks on the port's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !clk_en);

  property p_sel_gate;
    !q.sel_s |=> !mgmt_data_oe && q.st == ST_IDLE;
  endproperty
  a_sel_gate: assert property (p_sel_gate) else $error("driving while deselected");

  property p_sel_write;
    wr_stb |-> $past(q.sel_s);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("write while deselected");

  property p_addr_miss;
    q.sel_s && q.ready && !to_hit && !start_c && !stop_c && q.st == ST_RX && q.idx == 2'h0
      && scl_fall && q.cnt == BYTE_BITS && q.shift[7:1] != SLAVE_ADDR
      |=> q.st == ST_IDLE && !mgmt_data_oe;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address acked");

  property p_ack_byte;
    q.sel_s && q.ready && !to_hit && !start_c && !stop_c && q.st == ST_RX && scl_fall
      && q.cnt == BYTE_BITS && (q.idx != 2'h0 || q.shift[7:1] == SLAVE_ADDR)
      |=> q.st == ST_ACK && mgmt_data_oe;
  endproperty
  a_ack_byte: assert property (p_ack_byte) else $error("byte not acknowledged");

  property p_stable_high;
    $rose(mgmt_data_oe) |-> !$past(q.scl_s);
  endproperty
  a_stable_high: assert property (p_stable_high) else $error("data moved, clock high");

  property p_start;
    q.sel_s && q.ready && !to_hit && start_c |=> q.st == ST_RX && q.cnt == 4'h0;
  endproperty
  a_start: assert property (p_start) else $error("start missed");

  property p_stop;
    q.sel_s && q.ready && !to_hit && !start_c && stop_c |=> q.st == ST_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("stop missed");

  property p_timeout;
    q.sel_s && q.ready && to_hit |=> timeout_evt && q.st == ST_IDLE ##1 !timeout_evt;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not taken");

  property p_no_stretch;
    !serial_mgmt_clock_oe;
  endproperty
  a_no_stretch: assert property (p_no_stretch) else $error("clock stretched");

  property p_idle;
    q.scl_s && q.sda_s && q.hi_cnt == HI_W'(HIGH_CYC) |=> bus_idle;
  endproperty
  a_idle: assert property (p_idle) else $error("idle not flagged");

  property p_ready;
    !port_ready |-> q.rdy_cnt < RDY_W'(READY_DLY) && q.st == ST_IDLE;
  endproperty
  a_ready: assert property (p_ready) else $error("ready late or early use");

  property p_ro_write;
    wr_stb |-> wr_addr >= RO_COUNT && wr_addr < REG_LIMIT && $past(q.st) == ST_RX;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only written");

  c_write:   cover property (wr_stb);
  c_read:    cover property (q.st == ST_ACK ##[1:1000] q.st == ST_TX);
  c_timeout: cover property (timeout_evt);
  c_idle:    cover property (q.stop_seen && bus_idle);

endmodule

// [ssp_pkg.sv]
// Purpose: shared constants and types of the serial management slave port
// Assumes: 40 MHz system clock
// Notes:   timing counts other than READY_CYC are derived from times in their own units
package ssp_pkg;

  localparam int unsigned CLK_NS           = 25;
  // fixed 7-bit slave address, write byte reads as 8'hac
  localparam logic [6:0]  SLAVE_ADDR       = 7'h56;
  // bus-free time after stop, least time, rounded up
  localparam int unsigned T_BUF_NS         = 4700;
  localparam int unsigned BUF_CYC          = (T_BUF_NS + CLK_NS - 1) / CLK_NS;
  // longest clock-high time, rounded down
  localparam int unsigned T_HIGH_MAX_NS    = 50000;
  localparam int unsigned HIGH_CYC         = T_HIGH_MAX_NS / CLK_NS;
  localparam int unsigned HI_W             = 11;
  // clock-low timeout, detected at the least bound of its window
  localparam int unsigned T_TIMEOUT_MIN_MS = 25;
  localparam int unsigned TIMEOUT_CYC      = T_TIMEOUT_MIN_MS * 1000000 / CLK_NS;
  // power-up readiness bound and the much shorter delay used
  localparam int unsigned T_POR_MAX_MS     = 500;
  localparam int unsigned POR_MAX_CYC      = T_POR_MAX_MS * 1000000 / CLK_NS;
  localparam int unsigned READY_CYC        = 16;
  localparam int unsigned RDY_W            = 16;
  // byte framing
  localparam logic [3:0]  BYTE_BITS        = 4'h8;
  localparam logic [1:0]  IDX_DATA         = 2'h2;
  // register space: locations below RO_COUNT are read only
  localparam int unsigned REG_DEPTH        = 8;
  localparam int unsigned REG_AW           = 3;
  localparam logic [7:0]  RO_COUNT         = 8'h03;
  localparam logic [7:0]  REG_LIMIT        = 8'h08;
  localparam logic [63:0] REG_RST          = 64'h0000_0044_4400_0000;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_RACK = 5'h10
  } ssp_state_e;

endpackage

// [ssp_regmem.sv]
// Purpose: configuration register store with registered read data
// Assumes: one write port, one read port, same clock
// Notes:   writes land one cycle after the strobe; read data lag one cycle
`timescale 1ns/1ps
module ssp_regmem import ssp_pkg::*; #(
  parameter int unsigned DEPTH = REG_DEPTH,
  parameter int unsigned AW    = REG_AW,
  parameter int unsigned DW    = 8
) (
  input  wire logic          clk,
  input  wire logic          clk_en,
  input  wire logic          sys_rst,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_q
);

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0]            rdata;
  } ssp_mem_s;

  ssp_mem_s q;
  ssp_mem_s d;

  ////////////////////////////////////////////////////////////////////////////
  // next state: one write, one registered read
  always_comb begin
    d = q;
    if (we) begin
      d.mem[waddr] = wdata;
    end
    d.rdata = q.mem[raddr];
  end

  // reset loads the documented defaults per entry
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q.mem   <= REG_RST[DEPTH*DW-1:0];
      q.rdata <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign rdata_q = q.rdata;

endmodule

// [ssp_host_model.sv]
// Purpose: behavioural two-wire host master for the management slave port
// Assumes: both lines open-drain with pull-ups, resolved in this model
// Notes:   phases of 12 system cycles, above the slave's 10-cycle minimum
`timescale 1ns/1ps
module ssp_host_model (
  input  wire logic clk,
  input  wire logic dev_clk_oe,
  input  wire logic dev_data_oe,
  output logic      scl_line,
  output logic      sda_line
);
  logic scl_low;
  logic sda_low;

  ////////////////////////////////////////////////////////////////////////////
  // pull-ups win unless some party pulls the line low
  assign scl_line = ~(scl_low | dev_clk_oe);
  assign sda_line = ~(sda_low | dev_data_oe);

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  task automatic phase();
    repeat (12) @(negedge clk);
  endtask

  // start or repeated start; data released only while clock low
  task automatic start_c();
    sda_low = 1'b0;
    phase();
    scl_low = 1'b0;
    phase();
    sda_low = 1'b1;
    phase();
    scl_low = 1'b1;
    phase();
  endtask

  // stop, then leave the bus free for 200 cycles, just past the least free time
  task automatic stop_c();
    sda_low = 1'b1;
    phase();
    scl_low = 1'b0;
    phase();
    sda_low = 1'b0;
    repeat (200) @(negedge clk);
  endtask

  // data set while clock low, sampled at the end of the high phase
  task automatic bit_x(input logic b, output logic r);
    sda_low = ~b;
    phase();
    scl_low = 1'b0;
    phase();
    r = sda_line;
    scl_low = 1'b1;
  endtask

  // eight bits msb first, then the ninth with data released
  task automatic byte_x(input logic [7:0] d, output logic [7:0] r,
                        output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(1'b1, a);
    ack = ~a;
  endtask

  // clock left low, as a stuck host would
  task automatic hold_low(input int n);
    repeat (n) @(negedge clk);
  endtask
endmodule

// [testbench.sv]
// Purpose: self-checking bench of the management slave port
// Assumes: timeout count shortened to 200 cycles
// Notes:   inputs change on the falling clock edge only
`timescale 1ns/1ps
module testbench;
  logic       clk;
  logic       sys_rst;
  logic       port_sel;
  logic       scl_line;
  logic       sda_line;
  logic       scl_o;
  logic       scl_oe;
  logic       sda_o;
  logic       sda_oe;
  logic       port_ready;
  logic       bus_idle;
  logic       timeout_evt;
  logic       wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  int         n_mismatch = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         n_stb = 0;
  int         n_to = 0;
  int         n_sclo = 0;
  int         n_odv = 0;
  logic [7:0] last_a;
  logic [7:0] last_d;

  ////////////////////////////////////////////////////////////////////////////
  ssp_slave #(.TO_CYC(200)) dut_u (
    .clk(clk), .clk_en(1'b1), .sys_rst(sys_rst), .port_sel(port_sel),
    .serial_mgmt_clock_i(scl_line), .serial_mgmt_clock_o(scl_o),
    .serial_mgmt_clock_oe(scl_oe), .mgmt_data_i(sda_line), .mgmt_data_o(sda_o),
    .mgmt_data_oe(sda_oe), .port_ready(port_ready), .bus_idle(bus_idle),
    .timeout_evt(timeout_evt), .wr_stb(wr_stb), .wr_addr(wr_addr),
    .wr_data(wr_data));

  ssp_host_model host_u (
    .clk(clk), .dev_clk_oe(scl_oe), .dev_data_oe(sda_oe),
    .scl_line(scl_line), .sda_line(sda_line));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // watch pulses and pin drive off the launching edge; a hang ends the run
  always @(negedge clk) begin
    cyc++;
    if (wr_stb === 1'b1) begin
      n_stb++;
      last_a = wr_addr;
      last_d = wr_data;
    end
    if (timeout_evt === 1'b1) n_to++;
    if (scl_oe !== 1'b0) n_sclo++;
    if (sda_o !== 1'b0 || scl_o !== 1'b0) n_odv++;
    if (cyc == 80000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] rg,
                    input logic [7:0] dt, output logic [2:0] acks);
    logic [7:0] r;
    host_u.start_c();
    host_u.byte_x(adr, r, acks[2]);
    host_u.byte_x(rg, r, acks[1]);
    host_u.byte_x(dt, r, acks[0]);
    host_u.stop_c();
  endtask

  task automatic rd(input logic [7:0] rg, output logic [7:0] dt);
    logic [7:0] r;
    logic       a;
    host_u.start_c();
    host_u.byte_x(8'hAC, r, a);
    host_u.byte_x(rg, r, a);
    host_u.start_c();
    host_u.byte_x(8'hAD, r, a);
    host_u.byte_x(8'hFF, dt, a);
    host_u.stop_c();
  endtask

  // every location read back at its reset value
  task automatic t_defaults();
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      rd(i[7:0], d);
      chk("reset value", (i == 3 || i == 4) ? 8'h44 : 8'h00, d);
    end
  endtask

  // write acked three times, committed, read back, bus idle after
  task automatic t_write(input logic [7:0] rg, input logic [7:0] dt);
    logic [2:0] k;
    logic [7:0] d;
    int         s;
    s = n_stb;
    wr(8'hAC, rg, dt, k);
    chk("write acks", 8'h07, {5'h00, k});
    chk("strobes", 8'h01, 8'(n_stb - s));
    chk("commit addr", rg, last_a);
    chk("commit data", dt, last_d);
    chk("idle after stop", 8'h01, {7'h00, bus_idle});
    rd(rg, d);
    chk("read back", dt, d);
  endtask

  // refused writes: wrong address, deselected, read-only location
  task automatic t_refused();
    logic [2:0] k;
    logic [7:0] d;
    int         s;
    s = n_stb;
    wr(8'hAE, 8'h05, 8'h11, k);
    chk("foreign address acks", 8'h00, {5'h00, k});
    port_sel = 1'b0;
    repeat (5) @(negedge clk);
    wr(8'hAC, 8'h06, 8'h22, k);
    chk("deselected acks", 8'h00, {5'h00, k});
    port_sel = 1'b1;
    repeat (5) @(negedge clk);
    wr(8'hAC, 8'h01, 8'h77, k);
    chk("read-only acks", 8'h07, {5'h00, k});
    chk("refused strobes", 8'h00, 8'(n_stb - s));
    rd(8'h01, d);
    chk("read-only value", 8'h00, d);
    rd(8'h06, d);
    chk("deselected value", 8'h00, d);
  endtask

  // clock held low past the timeout abandons the message
  task automatic t_timeout();
    logic [7:0] r;
    logic       a;
    int         t;
    t = n_to;
    host_u.start_c();
    chk("idle after start", 8'h00, {7'h00, bus_idle});
    host_u.byte_x(8'hAC, r, a);
    host_u.hold_low(250);
    chk("timeouts", 8'h01, 8'(n_to - t));
    chk("data released", 8'h00, {7'h00, sda_oe});
    host_u.stop_c();
    t_write(8'h07, 8'h5A);
  endtask

  // two data bytes land in one register; a host-acked read moves on
  task automatic t_burst();
    logic [7:0] r;
    logic [7:0] d0;
    logic [7:0] d1;
    logic       a;
    int         s;
    s = n_stb;
    host_u.start_c();
    host_u.byte_x(8'hAC, r, a);
    host_u.byte_x(8'h06, r, a);
    host_u.byte_x(8'h3C, r, a);
    host_u.byte_x(8'hC3, r, a);
    chk("last data ack", 8'h01, {7'h00, a});
    host_u.stop_c();
    chk("burst strobes", 8'h02, 8'(n_stb - s));
    chk("burst addr", 8'h06, last_a);
    chk("burst data", 8'hC3, last_d);
    host_u.start_c();
    host_u.byte_x(8'hAC, r, a);
    host_u.byte_x(8'h05, r, a);
    host_u.start_c();
    host_u.byte_x(8'hAD, r, a);
    chk("read address ack", 8'h01, {7'h00, a});
    // first byte answered by the host with an ack asks for the next one
    for (int i = 7; i >= 0; i--) begin
      host_u.bit_x(1'b1, d0[i]);
    end
    host_u.bit_x(1'b0, a);
    host_u.byte_x(8'hFF, d1, a);
    host_u.stop_c();
    chk("burst first", 8'hA5, d0);
    chk("burst next", 8'hC3, d1);
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    port_sel = 1'b1;
    repeat (10) @(negedge clk);
    chk("oe in reset", 8'h00, {7'h00, sda_oe});
    sys_rst = 1'b0;
    @(negedge clk);
    chk("ready early", 8'h00, {7'h00, port_ready});
    repeat (20) @(negedge clk);
    chk("ready", 8'h01, {7'h00, port_ready});
    t_defaults();
    t_write(8'h05, 8'hA5);
    t_refused();
    t_timeout();
    t_burst();
    chk("stretch cycles", 8'h00, (n_sclo == 0) ? 8'h00 : 8'hFF);
    chk("open-drain values", 8'h00, (n_odv == 0) ? 8'h00 : 8'hFF);
    wrap_up();
  end
endmodule
